// >>> rtl/fetm_pkg.sv
// Shared constants and helpers for the front end trigger mux block
package fetm_pkg;
	// Bus geometry
	localparam int unsigned FETM_ADR_W = 32;
	localparam int unsigned FETM_DAT_W = 32;
	localparam int unsigned FETM_SEL_W = 4;

	// Register byte addresses
	localparam logic [31:0] FETM_FE1_ROUTE_ADDR = 32'h0012_0004;
	localparam logic [31:0] FETM_FE2_ROUTE_ADDR = 32'h0012_0008;
	localparam logic [31:0] FETM_TRIG_COUNT_ADDR = 32'h0012_0040;

	// Route register layout
	localparam int unsigned FETM_REG_W = 14;
	localparam int unsigned FETM_PWM_UNITS = 4;
	localparam int unsigned FETM_FIRST_LSB = 0;
	localparam int unsigned FETM_SECOND_LSB = 4;
	localparam int unsigned FETM_FSYNC_LSB = 8;
	localparam int unsigned FETM_GSEL_LSB = 12;
	localparam int unsigned FETM_GSEL_W = 2;
	localparam int unsigned FETM_LOW_LANE_W = 8;

	// Reset values of the two route registers
	localparam logic [13:0] FETM_FE1_RESET = 14'h1000;
	localparam logic [13:0] FETM_FE2_RESET = 14'h2000;

	// Gain-shift comparison source codes
	localparam logic [1:0] FETM_GSEL_FILTER0 = 2'h0;
	localparam logic [1:0] FETM_GSEL_FILTER1 = 2'h1;
	localparam logic [1:0] FETM_GSEL_FILTER2 = 2'h2;

	// Trigger event counter layout in the count register
	localparam int unsigned FETM_CNT_W = 16;
	localparam int unsigned FETM_CNT2_LSB = 16;

	// OR of every trigger source whose routing enable is set
	function automatic logic fetm_route_any(
		input logic [13:0] route,
		input logic [3:0] fsync,
		input logic [3:0] first,
		input logic [3:0] second
	);
		logic [3:0] hits;
		hits = (route[FETM_FSYNC_LSB +: FETM_PWM_UNITS] & fsync)
			| (route[FETM_SECOND_LSB +: FETM_PWM_UNITS] & second)
			| (route[FETM_FIRST_LSB +: FETM_PWM_UNITS] & first);
		return |hits;
	endfunction
endpackage

// >>> rtl/fetm_route_reg.sv
// One front end route register with byte-lane writes
`timescale 1ns/1ps
module fetm_route_reg #(
	parameter logic [13:0] RESET_VAL = 14'h0000
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic wr_en_i,
	input wire logic [1:0] sel_i,
	input wire logic [fetm_pkg::FETM_REG_W-1:0] wdata_i,
	output logic [fetm_pkg::FETM_REG_W-1:0] value_o
);
	import fetm_pkg::*;

	typedef struct packed {
		logic [FETM_REG_W-1:0] value;
	} fetm_rreg_state_t;

	fetm_rreg_state_t state_reg;
	fetm_rreg_state_t state_next;

	// Merge the enabled byte lanes, every field read back as written
	always_comb begin
		state_next = state_reg;
		if (wr_en_i && sel_i[0]) begin
			state_next.value[FETM_LOW_LANE_W-1:0] =
				wdata_i[FETM_LOW_LANE_W-1:0];
		end
		if (wr_en_i && sel_i[1]) begin
			state_next.value[FETM_REG_W-1:FETM_LOW_LANE_W] =
				wdata_i[FETM_REG_W-1:FETM_LOW_LANE_W];
		end
	end

	// Reset loads the filter choice and clears every enable
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg.value <= RESET_VAL;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign value_o = state_reg.value;
endmodule

// >>> rtl/fetm_route.sv
// Trigger routing and nonlinear result selection for one front end
`timescale 1ns/1ps
module fetm_route #(
	parameter int unsigned CMP_W = 4
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [fetm_pkg::FETM_REG_W-1:0] route_i,
	input wire logic [3:0] pwm_frame_sync_i,
	input wire logic [3:0] pwm_first_output_i,
	input wire logic [3:0] pwm_second_output_i,
	input wire logic [CMP_W-1:0] filter0_nonlinear_compare_i,
	input wire logic [CMP_W-1:0] filter1_nonlinear_compare_i,
	input wire logic [CMP_W-1:0] filter2_nonlinear_compare_i,
	output logic trigger_o,
	output logic [1:0] gain_shift_compare_source_o,
	output logic [CMP_W-1:0] nonlinear_compare_o
);
	import fetm_pkg::*;

	typedef struct packed {
		logic trigger;
		logic [FETM_GSEL_W-1:0] gsel;
		logic [CMP_W-1:0] cmp;
	} fetm_route_state_t;

	fetm_route_state_t state_reg;
	fetm_route_state_t state_next;
	logic [FETM_GSEL_W-1:0] gsel;

	assign gsel = route_i[FETM_GSEL_LSB +: FETM_GSEL_W];

	// Combine enabled triggers and pick the chosen filter's results
	always_comb begin
		state_next = state_reg;
		state_next.trigger = fetm_route_any(route_i, pwm_frame_sync_i,
			pwm_first_output_i, pwm_second_output_i);
		state_next.gsel = gsel;
		case (gsel)
			FETM_GSEL_FILTER0: state_next.cmp = filter0_nonlinear_compare_i;
			FETM_GSEL_FILTER1: state_next.cmp = filter1_nonlinear_compare_i;
			FETM_GSEL_FILTER2: state_next.cmp = filter2_nonlinear_compare_i;
			default: state_next.cmp = '0; // Undefined code gives no results
		endcase
	end

	// Output stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign trigger_o = state_reg.trigger;
	assign gain_shift_compare_source_o = state_reg.gsel;
	assign nonlinear_compare_o = state_reg.cmp;
endmodule

// >>> rtl/fetm_trigger_mux.sv
// Top of the front end trigger mux: Wishbone slave, registers, routing
`timescale 1ns/1ps

module fetm_trigger_mux #(
	parameter int unsigned CMP_W = 4
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [fetm_pkg::FETM_ADR_W-1:0] wb_adr_i,
	input wire logic [fetm_pkg::FETM_SEL_W-1:0] wb_sel_i,
	input wire logic [fetm_pkg::FETM_DAT_W-1:0] wb_dat_i,
	output logic [fetm_pkg::FETM_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] pwm_frame_sync_i,
	input wire logic [3:0] pwm_first_output_i,
	input wire logic [3:0] pwm_second_output_i,
	input wire logic [CMP_W-1:0] filter0_nonlinear_compare_i,
	input wire logic [CMP_W-1:0] filter1_nonlinear_compare_i,
	input wire logic [CMP_W-1:0] filter2_nonlinear_compare_i,
	output logic fe1_trigger_o,
	output logic fe2_trigger_o,
	output logic [1:0] fe1_gain_shift_compare_source_o,
	output logic [1:0] fe2_gain_shift_compare_source_o,
	output logic [CMP_W-1:0] fe1_nonlinear_compare_o,
	output logic [CMP_W-1:0] fe2_nonlinear_compare_o
);
	import fetm_pkg::*;

	typedef struct packed {
		logic ack;
		logic [FETM_DAT_W-1:0] rdata;
		logic [FETM_CNT_W-1:0] fe1_cnt;
		logic [FETM_CNT_W-1:0] fe2_cnt;
	} fetm_top_state_t;

	fetm_top_state_t state_reg;
	fetm_top_state_t state_next;

	logic req;
	logic wr_cycle;
	logic hit_fe1;
	logic hit_fe2;
	logic hit_cnt;
	logic [FETM_REG_W-1:0] fe1_route;
	logic [FETM_REG_W-1:0] fe2_route;
	logic fe1_trigger;
	logic fe2_trigger;

	// Address decode of the three words
	assign hit_fe1 = (wb_adr_i == FETM_FE1_ROUTE_ADDR);
	assign hit_fe2 = (wb_adr_i == FETM_FE2_ROUTE_ADDR);
	assign hit_cnt = (wb_adr_i == FETM_TRIG_COUNT_ADDR);

	// A new request is one not yet acknowledged
	assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;

	// Writes land on the edge at which the master samples ack
	assign wr_cycle = wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack;

	// Front end 1 route register
	fetm_route_reg #(
		.RESET_VAL(FETM_FE1_RESET)
	) u_fe1_reg (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.wr_en_i(wr_cycle && hit_fe1),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[FETM_REG_W-1:0]),
		.value_o(fe1_route)
	);

	// Front end 2 route register
	fetm_route_reg #(
		.RESET_VAL(FETM_FE2_RESET)
	) u_fe2_reg (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.wr_en_i(wr_cycle && hit_fe2),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[FETM_REG_W-1:0]),
		.value_o(fe2_route)
	);

	// Front end 1 routing
	fetm_route #(
		.CMP_W(CMP_W)
	) u_fe1_route (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.route_i(fe1_route),
		.pwm_frame_sync_i(pwm_frame_sync_i),
		.pwm_first_output_i(pwm_first_output_i),
		.pwm_second_output_i(pwm_second_output_i),
		.filter0_nonlinear_compare_i(filter0_nonlinear_compare_i),
		.filter1_nonlinear_compare_i(filter1_nonlinear_compare_i),
		.filter2_nonlinear_compare_i(filter2_nonlinear_compare_i),
		.trigger_o(fe1_trigger),
		.gain_shift_compare_source_o(fe1_gain_shift_compare_source_o),
		.nonlinear_compare_o(fe1_nonlinear_compare_o)
	);

	// Front end 2 routing
	fetm_route #(
		.CMP_W(CMP_W)
	) u_fe2_route (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.route_i(fe2_route),
		.pwm_frame_sync_i(pwm_frame_sync_i),
		.pwm_first_output_i(pwm_first_output_i),
		.pwm_second_output_i(pwm_second_output_i),
		.filter0_nonlinear_compare_i(filter0_nonlinear_compare_i),
		.filter1_nonlinear_compare_i(filter1_nonlinear_compare_i),
		.filter2_nonlinear_compare_i(filter2_nonlinear_compare_i),
		.trigger_o(fe2_trigger),
		.gain_shift_compare_source_o(fe2_gain_shift_compare_source_o),
		.nonlinear_compare_o(fe2_nonlinear_compare_o)
	);

	// Bus answer, read mux and trigger counters
	always_comb begin
		state_next = state_reg;
		// Ack one cycle after the request, dropped the cycle after
		state_next.ack = req;
		if (req) begin
			state_next.rdata = '0; // Unmapped words read as zero
			if (hit_fe1) begin
				state_next.rdata[FETM_REG_W-1:0] = fe1_route;
			end else if (hit_fe2) begin
				state_next.rdata[FETM_REG_W-1:0] = fe2_route;
			end else if (hit_cnt) begin
				state_next.rdata = {state_reg.fe2_cnt, state_reg.fe1_cnt};
			end
		end
		// Clearing write on a count lane, a same-cycle trigger still counts
		if (wr_cycle && hit_cnt && (wb_sel_i[1:0] != 2'h0)) begin
			state_next.fe1_cnt = {{(FETM_CNT_W-1){1'b0}}, fe1_trigger};
		end else if (fe1_trigger) begin
			state_next.fe1_cnt = state_reg.fe1_cnt + 16'h0001;
		end
		if (wr_cycle && hit_cnt && (wb_sel_i[3:2] != 2'h0)) begin
			state_next.fe2_cnt = {{(FETM_CNT_W-1){1'b0}}, fe2_trigger};
		end else if (fe2_trigger) begin
			state_next.fe2_cnt = state_reg.fe2_cnt + 16'h0001;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.rdata;
	assign fe1_trigger_o = fe1_trigger;
	assign fe2_trigger_o = fe2_trigger;
endmodule

// >>> testbench/fetm_trigger_mux_chk.sv
// Port assertions for the front end trigger mux
`timescale 1ns/1ps
module fetm_trigger_mux_chk
	import fetm_pkg::*;
#(
	parameter int unsigned CMP_W = 4
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [CMP_W-1:0] filter0_nonlinear_compare_i,
	input wire logic [CMP_W-1:0] filter1_nonlinear_compare_i,
	input wire logic [CMP_W-1:0] filter2_nonlinear_compare_i,
	input wire logic fe1_trigger_o,
	input wire logic fe2_trigger_o,
	input wire logic [1:0] fe1_gain_shift_compare_source_o,
	input wire logic [1:0] fe2_gain_shift_compare_source_o,
	input wire logic [CMP_W-1:0] fe1_nonlinear_compare_o,
	input wire logic [CMP_W-1:0] fe2_nonlinear_compare_o
);
	logic wr_seen_reg;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Notes any write since reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			wr_seen_reg <= 1'b0;
		else if (wb_cyc_i && wb_stb_i && wb_we_i)
			wr_seen_reg <= 1'b1;
	end
	// Filter result that a source code selects
	function automatic logic [CMP_W-1:0] pick(input logic [1:0] s,
		input logic [CMP_W-1:0] a, input logic [CMP_W-1:0] b,
		input logic [CMP_W-1:0] c);
		return (s == 2'h0) ? a : (s == 2'h1) ? b : (s == 2'h2) ? c : '0;
	endfunction
	a_ack_pulse:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_ack_answer:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("ack missing");
	a_ack_cause:
		assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack unasked");
	a_fe1_cmp_pick:
		assert property ($past(resetn_i) && $past(ce_i) |->
			fe1_nonlinear_compare_o == pick(fe1_gain_shift_compare_source_o,
			$past(filter0_nonlinear_compare_i),
			$past(filter1_nonlinear_compare_i),
			$past(filter2_nonlinear_compare_i))) else $error("fe1 pick");
	a_fe2_cmp_pick:
		assert property ($past(resetn_i) && $past(ce_i) |->
			fe2_nonlinear_compare_o == pick(fe2_gain_shift_compare_source_o,
			$past(filter0_nonlinear_compare_i),
			$past(filter1_nonlinear_compare_i),
			$past(filter2_nonlinear_compare_i))) else $error("fe2 pick");
	a_reset_blocks_all:
		assert property (!wr_seen_reg |-> !fe1_trigger_o && !fe2_trigger_o)
		else $error("trigger leak");
	a_upper_reads_zero:
		assert property (wb_ack_o && !wb_we_i && (wb_adr_i ==
			FETM_FE1_ROUTE_ADDR || wb_adr_i == FETM_FE2_ROUTE_ADDR) |->
			wb_dat_o[31:14] == 18'h0) else $error("upper bits");
	a_ce_freeze:
		assert property (!ce_i |=> $stable(wb_ack_o) &&
			$stable(fe1_gain_shift_compare_source_o)) else $error("ce");
	// Main scenarios
	cover property (fe1_trigger_o && !fe2_trigger_o);
	cover property (wb_ack_o && wb_we_i);
	cover property (!ce_i ##1 ce_i);
endmodule
bind fetm_trigger_mux fetm_trigger_mux_chk #(.CMP_W(CMP_W)) chk_i (.*);

// >>> testbench/fetm_pwm_model.sv
// Behavioural PWM units and loop filters on the signal side
`timescale 1ns/1ps
module fetm_pwm_model #(
	parameter int unsigned CMP_W = 4
) (
	input wire logic clk_i,
	input wire logic [11:0] src_i,
	output logic [3:0] frame_sync_o,
	output logic [3:0] second_o,
	output logic [3:0] first_o,
	output logic [CMP_W-1:0] f0_o,
	output logic [CMP_W-1:0] f1_o,
	output logic [CMP_W-1:0] f2_o
);
	logic [CMP_W-1:0] cnt_reg = '0;
	// Sources in register bit order; filter results differ every cycle
	always_ff @(posedge clk_i) begin
		{frame_sync_o, second_o, first_o} <= src_i;
		cnt_reg <= cnt_reg + 1'b1;
		f0_o <= cnt_reg;
		f1_o <= cnt_reg + 3'h3;
		f2_o <= cnt_reg + 3'h7;
	end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the front end trigger mux
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	miscompares++; $display("Error %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
	import fetm_pkg::*;
	logic clk_i = 0, resetn_i = 0, ce_i = 0, cyc = 0, stb = 0, we = 0, ack;
	logic [31:0] adr = 0, wdat = 0, rdat, q;
	logic [3:0] sel = 0, fs, sc, fi;
	logic [11:0] src = 0;
	logic [3:0] f0, f1, f2, cmp1, cmp2;
	logic [1:0] gs1, gs2;
	logic t1, t2;
	int miscompares = 0, comparisons = 0;
	always #25 clk_i = ~clk_i;
	fetm_pwm_model fetm_pwm_model_i (.clk_i(clk_i), .src_i(src),
		.frame_sync_o(fs), .second_o(sc), .first_o(fi),
		.f0_o(f0), .f1_o(f1), .f2_o(f2));
	fetm_trigger_mux fetm_trigger_mux_i (.clk_i(clk_i), .resetn_i(resetn_i),
		.ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pwm_frame_sync_i(fs), .pwm_first_output_i(fi),
		.pwm_second_output_i(sc), .filter0_nonlinear_compare_i(f0),
		.filter1_nonlinear_compare_i(f1), .filter2_nonlinear_compare_i(f2),
		.fe1_trigger_o(t1), .fe2_trigger_o(t2),
		.fe1_gain_shift_compare_source_o(gs1),
		.fe2_gain_shift_compare_source_o(gs2),
		.fe1_nonlinear_compare_o(cmp1), .fe2_nonlinear_compare_o(cmp2));
	// Prints the verdict and ends the run
	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One classic Wishbone cycle, held until ack is sampled
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		{cyc, stb, we} <= 3'b000;
		if (n >= 20) begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, 4'hF);
		`CHK(q, e)
	endtask
	// Drives PWM sources and checks both triggers one cycle after arrival
	task automatic trig(input logic [11:0] s, input logic e1, input logic e2);
		@(posedge clk_i);
		src <= s;
		repeat (2) @(posedge clk_i);
		#1 `CHK(t1, e1)
		`CHK(t2, e2)
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		ce_i <= 1'b1;
		rd(FETM_FE1_ROUTE_ADDR, 32'h0000_1000);
		rd(FETM_FE2_ROUTE_ADDR, 32'h0000_2000);
		`CHK(gs1, 2'h1)
		`CHK(gs2, 2'h2)
		trig(12'hFFF, 1'b0, 1'b0);
		$display("done: reset");
		for (int i = 0; i < 12; i++) begin
			xfer(1'b1, FETM_FE1_ROUTE_ADDR, 32'h1000 | (32'h1 << i), 4'hF);
			trig(12'h1 << i, 1'b1, 1'b0);
			trig(~(12'h1 << i), 1'b0, 1'b0);
		end
		xfer(1'b1, FETM_FE2_ROUTE_ADDR, 32'h0000_2FFF, 4'hF);
		trig(12'h024, 1'b0, 1'b1);
		trig(12'h900, 1'b1, 1'b1);
		xfer(1'b1, FETM_FE2_ROUTE_ADDR, 32'h0000_3F55, 4'h1);
		rd(FETM_FE2_ROUTE_ADDR, 32'h0000_2F55);
		$display("done: routing");
		for (logic [2:0] k = 0; k < 3; k++) begin
			xfer(1'b1, FETM_FE1_ROUTE_ADDR, {18'h0, k[1:0], 12'h0}, 4'hF);
			rd(FETM_FE1_ROUTE_ADDR, {18'h0, k[1:0], 12'h0});
			#1 `CHK(gs1, k[1:0])
		end
		rd(32'h0012_000C, 32'h0);
		// Clear both counts while front end 2 triggers every cycle
		xfer(1'b1, FETM_TRIG_COUNT_ADDR, 32'h0, 4'hF);
		rd(FETM_TRIG_COUNT_ADDR, 32'h0002_0000);
		@(posedge clk_i);
		ce_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		ce_i <= 1'b1;
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(FETM_FE1_ROUTE_ADDR, 32'h0000_1000);
		rd(FETM_TRIG_COUNT_ADDR, 32'h0);
		$display("done: select and reset");
		conclude();
	end
endmodule
